//--- hdl/cpgrc_top.sv
// Purpose: control logic of the clock pulse generator with RC oscillator control
// Assumes: oscillators are modelled as one-cycle ticks synchronous to ref_clk
// Notes:   Avalon-MM slave, one wait state per access, 8-bit registers
`timescale 1ns/1ps

// Function
// - one of RC or external clock drives system
// - prescaler yields phi/2 to phi/8192 enables
// - interrupt on external to RC switch
// - standby bit 7 stops RC oscillator
// - bit 6 selects 8 or 10 MHz
// - bit 5 selects reference or core supply
// - control bits 4 to 2 read zero
// - divide field: 0X none, 10 /2, 11 /4
// - divide writes only while switch status zero
// - protect write needs bit 7 zero; reads one
// - protect-update enable set/cleared by keyed write
// - bits 5,4 change only if update enabled
// - trim lock sticky until reset
// - trim write enable set/cleared by keyed write
// - trim data writable only unlocked and enabled
// - protect bits 3 to 0 read one
// - source select: 0 RC, 1 external
// - switch interrupt enable gates the flag onto the interrupt output; the flag sets regardless
module cpgrc_top
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // oscillator ticks
    input  wire logic        rcOscTick,
    input  wire logic        extClkTick,
    // oscillator controls
    output logic             rcStandby,
    output logic             rcFreqSelect,
    output logic             rcSupplySelect,
    output logic [7:0]       rcTrimData,
    // clocks and interrupt
    output logic             sysClkTick,
    output logic [12:0]      prescaleTick,
    output logic             clkSwitchIrq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    cpgrc_pkg::cpgrc_rcctl_type rcCtl_ff;
    cpgrc_pkg::cpgrc_prot_type  prot_ff;
    logic [7:0]                 trim_ff;
    logic                       srcSelect_ff;
    logic                       switchIe_ff;
    logic                       switchFlag_ff;
    logic                       switchStat_ff;
    logic                       waitReq_ff;
    logic [31:0]                readData_ff;
    logic                       sysTick_ff;
    logic                       irq_ff;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic       req;
    logic       wrDone;
    logic [7:0] wd;
    logic       wrCtl;
    logic       wrProt;
    logic       wrTrim;
    logic       wrStat;
    logic       keyOk;
    logic       rcDivTick;
    logic       rcRunTick;

    assign req    = avs_read || avs_write;
    assign wrDone = avs_write && !waitReq_ff && avs_byteenable[0];
    assign wd     = avs_writedata[7:0];
    assign wrCtl  = wrDone && (avs_address == cpgrc_pkg::ADDR_RC_CTRL);
    assign wrProt = wrDone && (avs_address == cpgrc_pkg::ADDR_TRIM_PROT);
    assign wrTrim = wrDone && (avs_address == cpgrc_pkg::ADDR_TRIM_DATA);
    assign wrStat = wrDone && (avs_address == cpgrc_pkg::ADDR_CLK_STATUS);
    assign keyOk  = !wd[cpgrc_pkg::BIT_WRITE_KEY_INHIBIT];

    // one wait state: waitrequest drops for one cycle per request
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            waitReq_ff <= 1'b1;
        else
            waitReq_ff <= !(req && waitReq_ff);
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            readData_ff <= 32'h0000_0000;
        else if (avs_read && waitReq_ff)
        begin
            readData_ff <= 32'h0000_0000;
            case (avs_address)
                cpgrc_pkg::ADDR_RC_CTRL:
                begin
                    readData_ff[cpgrc_pkg::BIT_RC_STANDBY]  <= rcCtl_ff.standby;
                    readData_ff[cpgrc_pkg::BIT_RC_FREQ_SEL] <= rcCtl_ff.freqSel;
                    readData_ff[cpgrc_pkg::BIT_RC_SUPPLY]   <= rcCtl_ff.supplySel;
                    readData_ff[cpgrc_pkg::BIT_RC_DIV_HI]   <= rcCtl_ff.divide[1];
                    readData_ff[cpgrc_pkg::BIT_RC_DIV_LO]   <= rcCtl_ff.divide[0];
                end
                cpgrc_pkg::ADDR_TRIM_PROT:
                begin
                    readData_ff[cpgrc_pkg::BIT_WRITE_KEY_INHIBIT] <= 1'b1;
                    readData_ff[cpgrc_pkg::BIT_PROTECT_UPDATE_EN] <= prot_ff.protectUpdateEn;
                    readData_ff[cpgrc_pkg::BIT_TRIM_LOCK]         <= prot_ff.trimLock;
                    readData_ff[cpgrc_pkg::BIT_TRIM_WRITE_EN]     <= prot_ff.trimWriteEn;
                    readData_ff[3:0] <= cpgrc_pkg::PROT_RESERVED_READ;
                end
                cpgrc_pkg::ADDR_TRIM_DATA:
                    readData_ff[7:0] <= trim_ff;
                cpgrc_pkg::ADDR_CLK_STATUS:
                begin
                    readData_ff[cpgrc_pkg::BIT_SRC_SELECT]  <= srcSelect_ff;
                    readData_ff[cpgrc_pkg::BIT_SWITCH_IE]   <= switchIe_ff;
                    readData_ff[cpgrc_pkg::BIT_SWITCH_FLAG] <= switchFlag_ff;
                    readData_ff[cpgrc_pkg::BIT_SWITCH_STAT] <= switchStat_ff;
                end
                default:
                    readData_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // rc_oscillator_control
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rcCtl_ff <= cpgrc_pkg::RCCTL_RESET;
        else if (wrCtl)
        begin
            rcCtl_ff.standby   <= wd[cpgrc_pkg::BIT_RC_STANDBY];
            rcCtl_ff.freqSel   <= wd[cpgrc_pkg::BIT_RC_FREQ_SEL];
            rcCtl_ff.supplySel <= wd[cpgrc_pkg::BIT_RC_SUPPLY];
            if (!switchStat_ff)
                rcCtl_ff.divide <= {wd[cpgrc_pkg::BIT_RC_DIV_HI], wd[cpgrc_pkg::BIT_RC_DIV_LO]};
        end
    end

    // ------------------------------------------------------------
    // trim_write_protect and rc_trim_data
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            prot_ff <= cpgrc_pkg::PROT_RESET;
        else if (wrProt && keyOk)
        begin
            prot_ff.protectUpdateEn <= wd[cpgrc_pkg::BIT_PROTECT_UPDATE_EN];
            if (prot_ff.protectUpdateEn)
            begin
                if (wd[cpgrc_pkg::BIT_TRIM_LOCK])
                    prot_ff.trimLock <= 1'b1;
                prot_ff.trimWriteEn <= wd[cpgrc_pkg::BIT_TRIM_WRITE_EN];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            trim_ff <= cpgrc_pkg::TRIM_RESET;
        else if (wrTrim && !prot_ff.trimLock && prot_ff.trimWriteEn)
            trim_ff <= wd & cpgrc_pkg::TRIM_WRITE_MASK;
    end

    // ------------------------------------------------------------
    // clock_control_status and switch interrupt
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            srcSelect_ff <= 1'b0;
            switchIe_ff  <= 1'b0;
        end
        else if (wrStat)
        begin
            srcSelect_ff <= wd[cpgrc_pkg::BIT_SRC_SELECT];
            switchIe_ff  <= wd[cpgrc_pkg::BIT_SWITCH_IE];
        end
    end

    // status follows the selector one cycle later; 1 means external clock
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            switchStat_ff <= 1'b0;
        else
            switchStat_ff <= srcSelect_ff;
    end

    // sticky flag, set wins over a software clear of 0
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            switchFlag_ff <= 1'b0;
        else if (switchStat_ff && !srcSelect_ff)
            switchFlag_ff <= 1'b1;
        else if (wrStat && !wd[cpgrc_pkg::BIT_SWITCH_FLAG])
            switchFlag_ff <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            irq_ff <= 1'b0;
        else
            irq_ff <= switchFlag_ff && switchIe_ff;
    end

    // ------------------------------------------------------------
    // clock path
    // ------------------------------------------------------------
    assign rcRunTick = rcOscTick && !rcCtl_ff.standby;

    cpgrc_rc_divider u_rcDiv
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .rcTick  (rcRunTick),
        .divide  (rcCtl_ff.divide),
        .divTick (rcDivTick)
    );

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sysTick_ff <= 1'b0;
        else
            sysTick_ff <= switchStat_ff ? extClkTick : rcDivTick;
    end

    cpgrc_prescaler #(.STAGES(cpgrc_pkg::PRESCALE_STAGES)) u_presc
    (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .sysTick    (sysTick_ff),
        .divTick_ff (prescaleTick)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata    = readData_ff;
    assign avs_waitrequest = waitReq_ff;
    assign rcStandby       = rcCtl_ff.standby;
    assign rcFreqSelect    = rcCtl_ff.freqSel;
    assign rcSupplySelect  = rcCtl_ff.supplySel;
    assign rcTrimData      = trim_ff;
    assign sysClkTick      = sysTick_ff;
    assign clkSwitchIrq    = irq_ff;
endmodule

//--- include/cpgrc_pkg.sv
// Purpose: shared constants and types of the clock pulse generator control block
// Assumes: Avalon-MM slave with 32-bit data, one aligned word per 8-bit register
// Notes:   register data sits in bits 7:0; upper bits read as zero
package cpgrc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_RC_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_TRIM_PROT  = 4'h4;
    localparam logic [3:0] ADDR_TRIM_DATA  = 4'h8;
    localparam logic [3:0] ADDR_CLK_STATUS = 4'hC;
    localparam int         ADDR_W          = 4;
    localparam int         DATA_W          = 32;

    // ------------------------------------------------------------
    // rc_oscillator_control fields
    // ------------------------------------------------------------
    localparam int BIT_RC_STANDBY  = 7;
    localparam int BIT_RC_FREQ_SEL = 6;
    localparam int BIT_RC_SUPPLY   = 5;
    localparam int BIT_RC_DIV_HI   = 1;
    localparam int BIT_RC_DIV_LO   = 0;

    // ------------------------------------------------------------
    // trim_write_protect fields
    // ------------------------------------------------------------
    localparam int         BIT_WRITE_KEY_INHIBIT = 7;
    localparam int         BIT_PROTECT_UPDATE_EN = 6;
    localparam int         BIT_TRIM_LOCK         = 5;
    localparam int         BIT_TRIM_WRITE_EN     = 4;
    localparam logic [3:0] PROT_RESERVED_READ    = 4'hF;

    // ------------------------------------------------------------
    // rc_trim_data: bits 1:0 read as zero, bits 7:2 writable
    // ------------------------------------------------------------
    localparam logic [7:0] TRIM_WRITE_MASK = 8'hFC;
    localparam logic [7:0] TRIM_RESET      = 8'h00;

    // ------------------------------------------------------------
    // clock_control_status fields
    // ------------------------------------------------------------
    localparam int BIT_SRC_SELECT  = 4;
    localparam int BIT_SWITCH_IE   = 3;
    localparam int BIT_SWITCH_FLAG = 2;
    localparam int BIT_SWITCH_STAT = 0;

    // ------------------------------------------------------------
    // divide field encodings and prescaler
    // ------------------------------------------------------------
    localparam logic [1:0] RC_DIV_BY2 = 2'h2;
    localparam logic [1:0] RC_DIV_BY4 = 2'h3;
    localparam int         PRESCALE_STAGES = 13;   // phi/2 .. phi/8192

    typedef struct packed {
        logic       standby;
        logic       freqSel;
        logic       supplySel;
        logic [1:0] divide;
    } cpgrc_rcctl_type;

    typedef struct packed {
        logic protectUpdateEn;
        logic trimLock;
        logic trimWriteEn;
    } cpgrc_prot_type;

    localparam cpgrc_rcctl_type RCCTL_RESET = '{1'b0, 1'b0, 1'b0, 2'h0};
    localparam cpgrc_prot_type  PROT_RESET  = '{1'b0, 1'b0, 1'b0};

endpackage

//--- hdl/cpgrc_rc_divider.sv
// Purpose: divides the RC oscillator tick by 1, 2 or 4
// Assumes: rcTick is a one-cycle enable at the oscillator rate
// Notes:   a new ratio applies from the next oscillator tick
`timescale 1ns/1ps
module cpgrc_rc_divider
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // control
    input  wire logic       rcTick,
    input  wire logic [1:0] divide,
    // output
    output logic            divTick
);
    logic [1:0] count_ff;
    logic [1:0] limit;

    always_comb
    begin
        case (divide)
            cpgrc_pkg::RC_DIV_BY2: limit = 2'h1;
            cpgrc_pkg::RC_DIV_BY4: limit = 2'h3;
            default:               limit = 2'h0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            count_ff <= 2'h0;
        else if (rcTick)
            count_ff <= (count_ff >= limit) ? 2'h0 : count_ff + 2'h1;
    end

    // ratio change immediate: compare against live limit
    assign divTick = rcTick && (count_ff >= limit);
endmodule

//--- hdl/cpgrc_prescaler.sv
// Purpose: derives phi/2 .. phi/8192 enables from the system tick
// Assumes: sysTick is a one-cycle enable at the system clock rate
// Notes:   stage i pulses once every 2^(i+1) system ticks
`timescale 1ns/1ps
module cpgrc_prescaler
#(
    parameter int STAGES = cpgrc_pkg::PRESCALE_STAGES
)
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // input tick
    input  wire logic              sysTick,
    // divided enables
    output logic [STAGES-1:0]      divTick_ff
);
    logic [STAGES-1:0] count_ff;
    logic [STAGES-1:0] allOnes;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            count_ff <= '0;
        else if (sysTick)
            count_ff <= count_ff + {{(STAGES-1){1'b0}}, 1'b1};
    end

    // stage i fires when its low counter bits are all ones
    genvar i;
    generate
        for (i = 0; i < STAGES; i++)
        begin : g_stage
            assign allOnes[i] = &count_ff[i:0];
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            divTick_ff <= '0;
        else
            divTick_ff <= sysTick ? allOnes : '0;
    end
endmodule

//--- verification/cpgrc_monitor.sv
// Purpose: concurrent checks on the clock pulse generator control ports
// Assumes: one wait state per bus access, registers in bits 7:0
// Notes:   bound to cpgrc_top, single clock domain
`timescale 1ns/1ps
module cpgrc_monitor
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register bus
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    // oscillator side
    input  wire logic        rcOscTick,
    input  wire logic        extClkTick,
    input  wire logic        rcStandby,
    input  wire logic        rcFreqSelect,
    input  wire logic        rcSupplySelect,
    input  wire logic        sysClkTick,
    input  wire logic [12:0] prescaleTick
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire rdDone = avs_read & ~avs_waitrequest;
    wire ctlWr  = avs_write & ~avs_waitrequest & avs_byteenable[0] & (avs_address == 4'h0);
    // ------------------------------------------------------------
    // bus, registers, clock path
    // ------------------------------------------------------------
    property p_wait_one; (avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer after one wait state");
    property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
    property p_ctl_reserved; rdDone && avs_address == 4'h0 |-> avs_readdata[4:2] == 3'h0; endproperty
    a_ctl_reserved: assert property (p_ctl_reserved) else $error("control reserved bits set");
    property p_prot_fixed; rdDone && avs_address == 4'h4 |-> avs_readdata[7] && avs_readdata[3:0] == 4'hF; endproperty
    a_prot_fixed: assert property (p_prot_fixed) else $error("protect fixed bits wrong");
    property p_standby; ctlWr |=> rcStandby == $past(avs_writedata[7]); endproperty
    a_standby: assert property (p_standby) else $error("standby not written");
    property p_freq; ctlWr |=> rcFreqSelect == $past(avs_writedata[6]); endproperty
    a_freq: assert property (p_freq) else $error("frequency select not written");
    property p_supply; ctlWr |=> rcSupplySelect == $past(avs_writedata[5]); endproperty
    a_supply: assert property (p_supply) else $error("supply select not written");
    property p_source; sysClkTick |-> $past(rcOscTick | extClkTick); endproperty
    a_source: assert property (p_source) else $error("system tick without source tick");
    property p_presc0; prescaleTick[0] |-> $past(sysClkTick); endproperty
    a_presc0: assert property (p_presc0) else $error("prescaler tick off system tick");
    property p_presc_chain; (prescaleTick[12:1] & ~prescaleTick[11:0]) == 12'h000; endproperty
    a_presc_chain: assert property (p_presc_chain) else $error("prescaler stage out of step");
    c_prot_read: cover property (rdDone && avs_address == 4'h4);
    c_standby: cover property (ctlWr && avs_writedata[7]);
    c_presc: cover property (prescaleTick[2]);
endmodule
bind cpgrc_top cpgrc_monitor u_monitor
(
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rcOscTick(rcOscTick), .extClkTick(extClkTick), .rcStandby(rcStandby),
    .rcFreqSelect(rcFreqSelect), .rcSupplySelect(rcSupplySelect), .sysClkTick(sysClkTick),
    .prescaleTick(prescaleTick)
);

//--- verification/cpgrc_bench.sv
// Purpose: self-checking bench of the clock pulse generator control block
// Assumes: one wait state per access, registers in bits 7:0
// Notes:   shadow registers predict every read, register output, irq and tick count
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; $display("Error %0t: got %h want %h", $time, a, e); end end
module cpgrc_bench;
    logic        ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, rcOscTick = 1'b0, extClkTick = 1'b0;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic        avs_waitrequest, rcStandby, rcFreqSelect, rcSupplySelect, sysClkTick, clkSwitchIrq;
    logic [7:0]  rcTrimData, rd, mCtl = 8'h00, mTrim = 8'h00;
    logic [12:0] prescaleTick;
    logic        mPe = 1'b0, mLock = 1'b0, mWe = 1'b0, mSrc = 1'b0, mIe = 1'b0, mFlag = 1'b0;
    int          fails = 0, check_count = 0, seed = 61, ticks = 0, n, p0 = 0, p2 = 0, tot = 0;
    logic [7:0]  ctlv [0:4] = '{8'hFF, 8'h00, 8'h01, 8'h02, 8'h03};
    logic [11:0] seq [0:9] = '{12'h4B0, 12'h430, 12'h440, 12'h450, 12'h8FF, 12'h460, 12'h450, 12'h800, 12'h400, 12'h410};
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (sysClkTick === 1'b1) ticks <= ticks + 1;
    always @(posedge ref_clk) if (prescaleTick[0] === 1'b1) p0 <= p0 + 1;
    always @(posedge ref_clk) if (prescaleTick[2] === 1'b1) p2 <= p2 + 1;
    cpgrc_top dut
    (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rcOscTick(rcOscTick), .extClkTick(extClkTick), .rcStandby(rcStandby),
        .rcFreqSelect(rcFreqSelect), .rcSupplySelect(rcSupplySelect), .rcTrimData(rcTrimData),
        .sysClkTick(sysClkTick), .prescaleTick(prescaleTick), .clkSwitchIrq(clkSwitchIrq)
    );
    // ------------------------------------------------------------
    // shadow model
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_rd(input logic [3:0] a);
        case (a)
            4'h0: return mCtl;
            4'h4: return {1'b1, mPe, mLock, mWe, 4'hF};
            4'h8: return mTrim;
            4'hC: return {3'b000, mSrc, mIe, mFlag, 1'b0, mSrc};
            default: return 8'h00;
        endcase
    endfunction
    task automatic model(input logic [3:0] a, input logic [7:0] d);
        case (a)
            4'h0: mCtl = mSrc ? {d[7:5], 3'b000, mCtl[1:0]} : (d & 8'hE3);
            4'h4: if (!d[7])
            begin
                if (mPe)
                begin
                    mLock = mLock | d[5];
                    mWe = d[4];
                end
                mPe = d[6];
            end
            4'h8: if (!mLock && mWe) mTrim = d & 8'hFC;
            4'hC: begin mFlag = (mFlag & d[2]) | (mSrc & ~d[4]); mSrc = d[4]; mIe = d[3]; end
            default: ;
        endcase
    endtask
    // ------------------------------------------------------------
    // bus cycles and scenarios
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int k;
        begin
            avs_address <= a;
            avs_writedata <= {24'h000000, d};
            avs_write <= wr;
            avs_read <= ~wr;
            k = 0;
            do
            begin
                @(posedge ref_clk);
                k++;
            end
            while (avs_waitrequest !== 1'b0 && k < 50);
            rd = avs_readdata[7:0];
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            if (k >= 50) fails++;
            if (wr) model(a, d);
            @(posedge ref_clk);
        end
    endtask
    task automatic step(input logic [3:0] a, input logic [7:0] d);
        begin
            bus(1'b1, a, d);
            bus(1'b0, a, 8'h00);
            `CHK(rd, exp_rd(a))
            `CHK(rcTrimData, mTrim)
            `CHK({rcStandby, rcFreqSelect, rcSupplySelect}, mCtl[7:5])
            `CHK(clkSwitchIrq, mFlag & mIe)
        end
    endtask
    task automatic pulses(input logic ext);
        int e;
        int t0;
        begin
            e = ext ? 8 : (mCtl[7] ? 0 : (mCtl[1] ? (mCtl[0] ? 2 : 4) : 8));
            t0 = ticks;
            tot += e;
            repeat (8)
            begin
                rcOscTick <= ~ext;
                extClkTick <= ext;
                @(posedge ref_clk);
                rcOscTick <= ext & 1'($random(seed));
                extClkTick <= ~ext & 1'($random(seed));
                @(posedge ref_clk);
            end
            rcOscTick <= 1'b0;
            extClkTick <= 1'b0;
            repeat (3) @(posedge ref_clk);
            `CHK(ticks - t0, e)
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", check_count, fails);
            if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (n = 0; n < 16; n += 2)
        begin
            bus(1'b0, 4'(n), 8'h00);
            `CHK(rd, exp_rd(4'(n)))
        end
        foreach (ctlv[i])
        begin
            step(4'h0, ctlv[i]);
            pulses(1'b0);
        end
        foreach (seq[i]) step(seq[i][11:8], seq[i][7:0]);
        step(4'hC, 8'h18);
        pulses(1'b1);
        step(4'h0, 8'h00);
        step(4'hC, 8'h0C);
        step(4'hC, 8'h04);
        step(4'hC, 8'h0C);
        step(4'hC, 8'h08);
        pulses(1'b0);
        repeat (2) @(posedge ref_clk);
        `CHK(p0, tot / 2)
        `CHK(p2, tot / 8)
        tally_and_finish();
    end
    initial
    begin
        #200000;
        fails++;
        tally_and_finish();
    end
endmodule
